// ---- design/fbm_pkg.sv ----
// package: register map, fields, reset values and timing for the fieldbus cycle control
`default_nettype none
package fbm_pkg;
  localparam logic [11:0] ADDR_CTRL     = 12'h000;
  localparam logic [11:0] ADDR_CFG0     = 12'h004;
  localparam logic [11:0] ADDR_CFG1     = 12'h008;
  localparam logic [11:0] ADDR_CFG2     = 12'h00c;
  localparam logic [11:0] ADDR_STATUS   = 12'h010;
  localparam logic [11:0] ADDR_BUSERR   = 12'h014;
  localparam logic [11:0] ADDR_REPCYC   = 12'h018;
  localparam logic [11:0] ADDR_CYCTIME  = 12'h01c;
  localparam logic [11:0] ADDR_CYCLAST  = 12'h020;
  localparam logic [11:0] ADDR_NODX     = 12'h024;
  localparam logic [11:0] ADDR_OVERRUN  = 12'h028;
  localparam logic [11:0] ADDR_LINKST   = 12'h02c;
  localparam logic [11:0] ADDR_DIAGRST  = 12'h030;
  // ctrl field positions
  localparam int CTRL_GAP_EN      = 0;
  localparam int CTRL_SLAVE_ROLE  = 1;
  localparam int CTRL_ACLR_LO     = 2;
  localparam int CTRL_STOP_HOLD   = 4;
  localparam int CTRL_REDUND      = 5;
  localparam int CTRL_NO_REL_UP   = 6;
  localparam int CTRL_NO_REL_DOWN = 7;
  localparam int CTRL_RUN         = 8;
  localparam int CTRL_STOPPED     = 9;
  localparam logic [9:0] CTRL_RESET = 10'h000;
  // cfg0: retry limit [3:0], highest station address [14:8], gap factor [23:16]
  localparam logic [31:0] CFG0_RESET = 32'h00647e04;
  // cfg1: token rotation target in cycles
  localparam logic [31:0] CFG1_RESET = 32'h00008db6;
  // cfg2: startup interval in 1 ms units [7:0], clear tolerance [15:8], operate delay ms [23:16]
  localparam logic [31:0] CFG2_RESET = 32'h0000000a;
  localparam int CLK_MHZ     = 100;
  localparam int MS_US       = 1000;
  localparam int MS_CYCLES   = CLK_MHZ * MS_US;
  localparam int NSLAVE      = 8;
  localparam logic [15:0] STAT_MAX = 16'hffff;
  typedef enum logic [1:0] {ACLR_OFF, ACLR_MC, ACLR_ALL} aclr_t;
  typedef enum logic [1:0] {PH_IDLE, PH_RELEASE, PH_STARTUP, PH_CYCLIC} phase_t;
  typedef struct packed {
    logic       done;
    logic [7:0] linkState;
    logic [3:0] repeats;
  } cyc_rep_t;
endpackage
`default_nettype wire

// ---- design/fieldbus_master_cycle_control.sv ----
// fieldbus master cycle control: retry policy, presence poll, clear/operate, diagnostics
// Functional notes
// RULE_01: a retry limit of zero is accepted; missed exchange is not repeated.
// RULE_02: unanswered slave gets nonzero link state for that single cycle.
// RULE_03: presence poll up to highest station address when enabled; off at reset.
// RULE_04: poll rounds spaced by gap factor times token rotation target.
// RULE_05: startup telegrams per slave no faster than the startup send interval.
// RULE_06: bus role master or slave selectable, master after reset.
// RULE_07: auto-clear forces Clear while MC or any slave link state nonzero.
// RULE_08: Clear after missing host ticks exceed tolerance, regardless of auto-clear.
// RULE_09: host task start moves Clear to Operate after the operate delay.
// RULE_10: Clear sends zero or safe outputs; Operate sends host outputs.
// RULE_11: on host stop outputs forced to zero or held, by option.
// RULE_12: redundancy mode only listens, never transmits.
// RULE_13: connections released at startup unless suppressed.
// RULE_14: connections released at shutdown unless suppressed.
// RULE_15: every detected bus error counted, readable by host.
// RULE_16: count cycles with repeats; record maximum repeats per cycle.
// RULE_17: min, max, last cycle time over clean full-exchange cycles.
// RULE_18: incomplete exchange counter counts cycles with nonzero link state.
// RULE_19: overrun counted when full-exchange cycle unfinished at next tick.
// RULE_20: wait up to slot time for response, then repeat or move on.
// RULE_21: repeat an unanswered telegram at most retry limit times.
// RULE_22: diagnostic reset command clears counters and cycle time extremes.
//
// Our own choices: register access over APB and the address map.
`default_nettype none
module fieldbus_master_cycle_control
  import fbm_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // apb
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // host task
  input  wire logic              hostTick,
  input  wire logic [7:0]        hostOut,
  input  wire logic [7:0]        safeOut,
  input  wire logic [7:0]        mcMask,
  // bus engine
  input  wire fbm_pkg::cyc_rep_t cycRep,
  input  wire logic              busErrPin,
  input  wire logic              rxActive,
  input  wire logic              respOk,
  input  wire logic [15:0]       slotTime,
  output logic                   txSend,
  output logic                   txRepeat,
  output logic [6:0]             txAddr,
  output logic                   txGap,
  output logic                   txStartup,
  output logic                   txRelease,
  output logic [7:0]             slaveOut,
  output logic                   operate,
  output logic                   slaveRole
);
  import fbm_pkg::*;

  logic [9:0]  ctrl_r;
  logic [31:0] cfg0_r, cfg1_r, cfg2_r;
  logic [15:0] busErr_r, repCyc_r, noDx_r, overrun_r;
  logic [3:0]  maxRep_r;
  logic [15:0] cycMin_r, cycMax_r, cycLast_r, cycCnt_r;
  logic [7:0]  linkSt_r;
  logic        diagRst;
  logic        busErrS1_r, busErrS2_r, busErrS3_r;
  logic        cycOpen_r;
  logic [7:0]  missCnt_r;
  logic        tickSeen_r;
  logic        operate_r;
  logic        opPend_r;
  logic [31:0] opCnt_r;
  logic [31:0] gapCnt_r;
  logic [6:0]  gapAddr_r;
  logic        gapBusy_r;
  logic [31:0] upCnt_r;
  logic [2:0]  upIdx_r;
  logic [7:0]  upMs_r;
  phase_t      phase_r;
  logic        relDone_r;
  logic [15:0] slotCnt_r;
  logic        waitResp_r;
  logic [3:0]  tries_r;
  logic        runPrev_r;
  logic [7:0]  out_r;
  logic        txSend_r, txRep_r, txGap_r, txSt_r, txRel_r;
  logic [6:0]  txAddr_r;
  logic [31:0] prdata_r;
  logic        pready_r, pslverr_r;

  // decode
  wire         apbSetup   = psel && !penable;
  wire         apbWr      = psel && penable && pwrite && pready_r;
  wire         apbRd      = apbSetup && !pwrite;
  wire  [3:0]  retryLim   = cfg0_r[3:0];
  wire  [6:0]  highest_station_address        = cfg0_r[14:8];
  wire  [7:0]  gapFactor  = cfg0_r[23:16];
  wire  [7:0]  upMs       = cfg2_r[7:0];
  wire  [7:0]  clrTol     = cfg2_r[15:8];
  wire  [7:0]  opDelayMs  = cfg2_r[23:16];
  wire  [1:0]  aclrMode   = ctrl_r[CTRL_ACLR_LO +: 2];
  wire         redund     = ctrl_r[CTRL_REDUND];
  wire         run        = ctrl_r[CTRL_RUN];
  wire         txAllowed  = !redund && !ctrl_r[CTRL_SLAVE_ROLE]; // RULE_12
  wire  [31:0] gapPeriod  = 32'(gapFactor) * cfg1_r; // RULE_04
  wire  [31:0] opDelayCyc = 32'(opDelayMs) * 32'(MS_CYCLES);
  // auto-clear looks at the last reported link states, the done report is only a pulse
  wire  [7:0]  mcBad      = linkSt_r & mcMask;
  wire         anyBad     = |cycRep.linkState;
  wire         aclrHold   = (aclrMode == 2'(ACLR_MC) && |mcBad) ||
                            (aclrMode == 2'(ACLR_ALL) && |linkSt_r); // RULE_07
  wire         missOver   = missCnt_r > clrTol; // RULE_08
  wire         cleanCyc   = cycRep.done && !anyBad && cycRep.repeats == 4'h0;
  wire         busErrEv   = busErrS2_r && !busErrS3_r;
  wire         slotOut    = waitResp_r && slotCnt_r >= slotTime;

  function automatic logic [31:0] rd_mux(input logic [11:0] a);
    case (a)
      ADDR_CTRL:    rd_mux = {22'h0, ctrl_r};
      ADDR_CFG0:    rd_mux = cfg0_r;
      ADDR_CFG1:    rd_mux = cfg1_r;
      ADDR_CFG2:    rd_mux = cfg2_r;
      ADDR_STATUS:  rd_mux = {24'h0, 2'(phase_r), gapBusy_r, opPend_r, 3'h0, operate_r};
      ADDR_BUSERR:  rd_mux = {16'h0, busErr_r};
      ADDR_REPCYC:  rd_mux = {12'h0, maxRep_r, repCyc_r};
      ADDR_CYCTIME: rd_mux = {cycMax_r, cycMin_r};
      ADDR_CYCLAST: rd_mux = {16'h0, cycLast_r};
      ADDR_NODX:    rd_mux = {16'h0, noDx_r};
      ADDR_OVERRUN: rd_mux = {16'h0, overrun_r};
      ADDR_LINKST:  rd_mux = {24'h0, linkSt_r};
      ADDR_DIAGRST: rd_mux = 32'h0;
      default:      rd_mux = 32'h0;
    endcase
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    mapped = a <= ADDR_DIAGRST && a[1:0] == 2'h0;
  endfunction

  assign diagRst = apbWr && paddr == ADDR_DIAGRST && pwdata[0]; // RULE_22

  // apb slave: no wait states, unmapped returns error
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0;
    end else begin
      pready_r  <= apbSetup;
      pslverr_r <= apbSetup && !mapped(paddr);
      prdata_r  <= apbRd ? rd_mux(paddr) : 32'h0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_r <= CTRL_RESET; // RULE_03 RULE_06
      cfg0_r <= CFG0_RESET;
      cfg1_r <= CFG1_RESET;
      cfg2_r <= CFG2_RESET;
    end else if (apbWr) begin
      if (paddr == ADDR_CTRL) ctrl_r <= pwdata[9:0];
      if (paddr == ADDR_CFG0) cfg0_r <= pwdata;
      if (paddr == ADDR_CFG1) cfg1_r <= pwdata;
      if (paddr == ADDR_CFG2) cfg2_r <= pwdata;
    end
  end

  // bus error pin synchroniser; edge taken after the second stage
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busErrS1_r <= 1'b0;
      busErrS2_r <= 1'b0;
      busErrS3_r <= 1'b0;
    end else begin
      busErrS1_r <= busErrPin;
      busErrS2_r <= busErrS1_r;
      busErrS3_r <= busErrS2_r;
    end
  end

  // diagnostics; counters saturate rather than wrap so a long fault stays visible
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busErr_r  <= 16'h0;
      repCyc_r  <= 16'h0;
      maxRep_r  <= 4'h0;
      noDx_r    <= 16'h0;
      overrun_r <= 16'h0;
      cycMin_r  <= STAT_MAX;
      cycMax_r  <= 16'h0;
      cycLast_r <= 16'h0;
      linkSt_r  <= 8'h0;
    end else if (diagRst) begin
      busErr_r  <= 16'h0;
      repCyc_r  <= 16'h0;
      maxRep_r  <= 4'h0;
      noDx_r    <= 16'h0;
      overrun_r <= 16'h0;
      cycMin_r  <= STAT_MAX;
      cycMax_r  <= 16'h0;
      cycLast_r <= 16'h0;
    end else begin
      if (busErrEv && busErr_r != STAT_MAX) busErr_r <= busErr_r + 16'h1; // RULE_15
      if (cycRep.done) begin
        linkSt_r <= cycRep.linkState; // RULE_02
        if (cycRep.repeats != 4'h0 && repCyc_r != STAT_MAX)
          repCyc_r <= repCyc_r + 16'h1; // RULE_16
        if (cycRep.repeats > maxRep_r) maxRep_r <= cycRep.repeats; // RULE_16
        if (anyBad && noDx_r != STAT_MAX) noDx_r <= noDx_r + 16'h1; // RULE_18
      end
      if (cleanCyc) begin
        cycLast_r <= cycCnt_r; // RULE_17
        if (cycCnt_r < cycMin_r) cycMin_r <= cycCnt_r;
        if (cycCnt_r > cycMax_r) cycMax_r <= cycCnt_r;
      end
      if (hostTick && cycOpen_r && linkSt_r == 8'h0 && overrun_r != STAT_MAX)
        overrun_r <= overrun_r + 16'h1; // RULE_19
    end
  end

  // cycle timing: a cycle opens at a host tick and closes at the done report
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cycOpen_r <= 1'b0;
      cycCnt_r  <= 16'h0;
    end else begin
      if (hostTick) begin
        cycOpen_r <= 1'b1;
        cycCnt_r  <= 16'h1;
      end else if (cycRep.done) begin
        cycOpen_r <= 1'b0;
      end else if (cycOpen_r && cycCnt_r != STAT_MAX) begin
        cycCnt_r <= cycCnt_r + 16'h1;
      end
    end
  end

  // clear/operate: missing ticks are counted once per bus cycle done report
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      missCnt_r  <= 8'h0;
      tickSeen_r <= 1'b0;
      operate_r  <= 1'b0;
      opPend_r   <= 1'b0;
      opCnt_r    <= 32'h0;
      runPrev_r  <= 1'b0;
    end else begin
      runPrev_r <= run;
      if (hostTick) tickSeen_r <= 1'b1;
      else if (cycRep.done) tickSeen_r <= 1'b0;
      // a bus cycle closed with no tick since the previous close is one missing tick
      if (cycRep.done) begin
        if (hostTick || tickSeen_r) missCnt_r <= 8'h0;
        else if (missCnt_r != 8'hff) missCnt_r <= missCnt_r + 8'h1;
      end
      if (!run || missOver || aclrHold) begin // RULE_07 RULE_08
        operate_r <= 1'b0;
        opPend_r  <= run && !missOver;
        opCnt_r   <= 32'h0;
      end else if (!operate_r) begin
        opPend_r <= 1'b1;
        if (opCnt_r >= opDelayCyc) begin
          operate_r <= 1'b1; // RULE_09
          opPend_r  <= 1'b0;
        end else begin
          opCnt_r <= opCnt_r + 32'h1;
        end
      end
    end
  end

  // output image; host stop either zeroes or freezes the last values
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      out_r <= 8'h0;
    end else if (ctrl_r[CTRL_STOPPED]) begin
      if (!ctrl_r[CTRL_STOP_HOLD]) out_r <= 8'h0; // RULE_11
    end else begin
      out_r <= operate_r ? hostOut : safeOut; // RULE_10
    end
  end

  // link phase: release, startup, cyclic; shutdown release on fall of run
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_r   <= PH_IDLE;
      relDone_r <= 1'b0;
      upCnt_r   <= 32'h0;
      upIdx_r   <= 3'h0;
      upMs_r    <= 8'h0;
    end else begin
      case (phase_r)
        PH_IDLE: begin
          relDone_r <= 1'b0;
          if (run && !runPrev_r)
            phase_r <= ctrl_r[CTRL_NO_REL_UP] ? PH_STARTUP : PH_RELEASE; // RULE_13
        end
        PH_RELEASE: phase_r <= PH_STARTUP;
        PH_STARTUP: begin
          if (!run) begin
            phase_r <= PH_IDLE;
          end else if (upCnt_r == 32'(MS_CYCLES - 1)) begin
            upCnt_r <= 32'h0;
            if (upMs == 8'h0 || upMs_r >= upMs - 8'h1) begin // RULE_05
              upMs_r  <= 8'h0;
              upIdx_r <= upIdx_r + 3'h1;
              if (upIdx_r == 3'(NSLAVE - 1)) phase_r <= PH_CYCLIC;
            end else begin
              upMs_r <= upMs_r + 8'h1;
            end
          end else begin
            upCnt_r <= upCnt_r + 32'h1;
          end
        end
        PH_CYCLIC: if (!run) phase_r <= PH_IDLE;
        default: phase_r <= PH_IDLE;
      endcase
    end
  end

  // presence poll timer and address walk
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gapCnt_r  <= 32'h0;
      gapAddr_r <= 7'h0;
      gapBusy_r <= 1'b0;
    end else if (!ctrl_r[CTRL_GAP_EN]) begin
      gapCnt_r  <= 32'h0;
      gapBusy_r <= 1'b0;
    end else if (gapBusy_r) begin
      if (!waitResp_r && !rxActive) begin
        gapAddr_r <= gapAddr_r + 7'h1;
        if (gapAddr_r >= highest_station_address) gapBusy_r <= 1'b0; // RULE_03
      end
    end else if (gapCnt_r + 32'h1 >= gapPeriod) begin
      gapCnt_r  <= 32'h0; // RULE_04
      gapBusy_r <= 1'b1;
      gapAddr_r <= 7'h0;
    end else begin
      gapCnt_r <= gapCnt_r + 32'h1;
    end
  end

  // telegram strobes and response wait for poll telegrams
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      txSend_r   <= 1'b0;
      txRep_r    <= 1'b0;
      txGap_r    <= 1'b0;
      txSt_r     <= 1'b0;
      txRel_r    <= 1'b0;
      txAddr_r   <= 7'h0;
      waitResp_r <= 1'b0;
      slotCnt_r  <= 16'h0;
      tries_r    <= 4'h0;
    end else begin
      txSend_r <= 1'b0;
      txRep_r  <= 1'b0;
      txGap_r  <= 1'b0;
      txSt_r   <= txAllowed && phase_r == PH_STARTUP && upCnt_r == 32'h0 && upMs_r == 8'h0;
      txRel_r  <= txAllowed && (phase_r == PH_RELEASE || // RULE_13
                  (phase_r != PH_IDLE && !run && !ctrl_r[CTRL_NO_REL_DOWN])); // RULE_14
      if (waitResp_r) begin
        slotCnt_r <= slotCnt_r + 16'h1;
        if (respOk) begin
          waitResp_r <= 1'b0;
        end else if (slotOut) begin // RULE_20
          slotCnt_r <= 16'h0;
          if (tries_r < retryLim && txAllowed) begin // RULE_01 RULE_21 RULE_12
            tries_r  <= tries_r + 4'h1;
            txSend_r <= 1'b1;
            txRep_r  <= 1'b1;
          end else begin
            waitResp_r <= 1'b0;
          end
        end
      end else if (txAllowed && gapBusy_r && !rxActive && !txGap_r) begin
        txSend_r   <= 1'b1;
        txGap_r    <= 1'b1;
        txAddr_r   <= gapAddr_r;
        waitResp_r <= 1'b1;
        slotCnt_r  <= 16'h0;
        tries_r    <= 4'h0;
      end
    end
  end

  assign prdata    = prdata_r;
  assign pready    = pready_r;
  assign pslverr   = pslverr_r;
  assign txSend    = txSend_r;
  assign txRepeat  = txRep_r;
  assign txAddr    = txAddr_r;
  assign txGap     = txGap_r;
  assign txStartup = txSt_r;
  assign txRelease = txRel_r;
  assign slaveOut  = out_r;
  assign operate   = operate_r;
  assign slaveRole = ctrl_r[CTRL_SLAVE_ROLE]; // RULE_06

  a_silent_redund: assert property (@(posedge clk) disable iff (!nrst) // RULE_12
    redund |=> !txSend && !txStartup)
    else $error("telegram sent in listen-only mode");
  a_clear_on_miss: assert property (@(posedge clk) disable iff (!nrst) // RULE_08
    missOver |=> !operate)
    else $error("operate despite missed host ticks");
  a_aclr_clear: assert property (@(posedge clk) disable iff (!nrst) // RULE_07
    aclrHold |=> !operate)
    else $error("operate while auto-clear condition holds");
  a_retry_bound: assert property (@(posedge clk) disable iff (!nrst) // RULE_21
    txRepeat |-> tries_r <= retryLim && tries_r != 4'h0)
    else $error("repeat beyond retry limit");
  a_retry_zero: assert property (@(posedge clk) disable iff (!nrst) // RULE_01
    retryLim == 4'h0 && $stable(retryLim) |-> !txRepeat)
    else $error("repeat with zero retry limit");
  a_clear_outputs: assert property (@(posedge clk) disable iff (!nrst) // RULE_10
    !operate_r && !ctrl_r[CTRL_STOPPED] |=> slaveOut == $past(safeOut))
    else $error("clear outputs not safe values");
  a_diag_reset: assert property (@(posedge clk) disable iff (!nrst) // RULE_22
    diagRst |=> busErr_r == 16'h0 && repCyc_r == 16'h0 && cycMax_r == 16'h0)
    else $error("diagnostics not cleared");
  a_gap_off: assert property (@(posedge clk) disable iff (!nrst) // RULE_03
    !ctrl_r[CTRL_GAP_EN] |=> !gapBusy_r)
    else $error("presence poll active while disabled");
  a_buserr_cnt: assert property (@(posedge clk) disable iff (!nrst) // RULE_15
    busErrEv && !diagRst && busErr_r < 16'hfffe |=> busErr_r == $past(busErr_r) + 16'h1)
    else $error("bus error not counted");
  c_operate: cover property (@(posedge clk) disable iff (!nrst) $rose(operate_r));
  c_repeat: cover property (@(posedge clk) disable iff (!nrst) txRepeat);
  c_gap_round: cover property (@(posedge clk) disable iff (!nrst) $fell(gapBusy_r));
  c_overrun: cover property (@(posedge clk) disable iff (!nrst) hostTick && cycOpen_r);
endmodule
`default_nettype wire

// ---- test/fbm_station_model.sv ----
// slave station model answering presence polls on the fieldbus
`default_nettype none
module fbm_station_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // poll link
  input  wire logic       txSend,
  input  wire logic [6:0] txAddr,
  input  wire logic [7:0] present,
  input  wire logic       slow,
  output logic            respOk,
  output logic            rxActive
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] waitCnt;
  // only stations 0..7 exist; absent ones stay silent so the master times out and repeats up to its retry limit
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      waitCnt <= 5'h00;
      respOk  <= 1'b0;
    end else begin
      respOk <= 1'b0;
      if (txSend && txAddr < 7'h08 && present[txAddr[2:0]]) begin
        waitCnt <= slow ? 5'h0c : 5'h02;
      end else if (waitCnt != 5'h00) begin
        waitCnt <= waitCnt - 5'h01;
        respOk  <= (waitCnt == 5'h01);
      end
    end
  end
  assign rxActive = (waitCnt != 5'h00);
endmodule
`default_nettype wire

// ---- test/test_fieldbus_master_cycle_control.sv ----
// self-checking bench for the fieldbus master cycle control
`default_nettype none
module test_fieldbus_master_cycle_control;
  timeunit 1ns;
  timeprecision 1ps;
  import fbm_pkg::*;
  logic clk, nrst, psel, penable, pwrite, pready, pslverr, hostTick, busErrPin, rxActive, respOk;
  logic txSend, txRepeat, txGap, txStartup, txRelease, operate, slaveRole, slow, err, open;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, rq;
  logic [7:0] hostOut, safeOut, mcMask, slaveOut, present, lastLs, ls, lsSel;
  logic [6:0] txAddr;
  logic [3:0] ph, rp, expMax;
  logic [127:0] seen;
  cyc_rep_t cycRep;
  int fail_count, n_compared, seed, cyc, n, nSend, nRep, run, maxRun, nRel, lastGap, minGap;
  int expRepN, expNoDx, expOv;
  bit tickOn, doneOn, rndOn;
  fieldbus_master_cycle_control dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hostTick(hostTick), .hostOut(hostOut), .safeOut(safeOut),
    .mcMask(mcMask), .cycRep(cycRep), .busErrPin(busErrPin), .rxActive(rxActive),
    .respOk(respOk), .slotTime(16'h0014), .txSend(txSend), .txRepeat(txRepeat),
    .txAddr(txAddr), .txGap(txGap), .txStartup(txStartup), .txRelease(txRelease),
    .slaveOut(slaveOut), .operate(operate), .slaveRole(slaveRole));
  fbm_station_model stations (.clk(clk), .nrst(nrst), .txSend(txSend), .txAddr(txAddr),
    .present(present), .slow(slow), .respOk(respOk), .rxActive(rxActive));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic test_done();
    if (fail_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", nm, exp, got);
      fail_count++;
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) fail_count++;
  endtask
  task automatic waitOp(input logic v);
    int k;
    for (k = 0; k < 3000 && operate !== v; k++) @(posedge clk);
  endtask
  task automatic clrMon();
    nSend = 0; nRep = 0; maxRun = 0; nRel = 0; seen = '0; lastGap = 0; minGap = 99999;
  endtask
  // monitor of the bus engine outputs, plus the run limit
  always @(posedge clk) begin
    cyc++;
    if (cyc >= 40000) begin
      fail_count++;
      test_done();
    end
    if (txSend === 1'b1) begin
      nSend++;
      seen[txAddr] = 1'b1;
      run = (txRepeat === 1'b1) ? run + 1 : 0;
      if (txRepeat === 1'b1) nRep++;
      if (run > maxRun) maxRun = run;
    end
    if (txGap === 1'b1 && txAddr == 7'h03) begin
      if (lastGap != 0 && cyc - lastGap < minGap) minGap = cyc - lastGap;
      lastGap = cyc;
    end
    if (txRelease === 1'b1) nRel++;
  end
  // host task tick every 16 cycles, bus cycle report 8 cycles after it
  always @(posedge clk) begin
    ph = ph + 4'h1;
    hostTick <= (nrst === 1'b1) && tickOn && ph == 4'h0;
    if (nrst && tickOn && ph == 4'h0) begin
      if (open && lastLs == 8'h00) expOv++;
      open = 1'b1;
    end
    if (nrst && doneOn && ph == 4'h8) begin
      rq = $random(seed);
      ls = rndOn ? ((rq[1:0] == 2'b00) ? rq[15:8] : 8'h00) : lsSel;
      rp = rndOn ? {2'b00, rq[17:16]} : 4'h0;
      cycRep <= '{done: 1'b1, linkState: ls, repeats: rp};
      lastLs = ls;
      open = 1'b0;
      if (rp != 4'h0) expRepN++;
      if (rp > expMax) expMax = rp;
      if (ls != 8'h00) expNoDx++;
    end else begin
      cycRep <= '0;
    end
  end
  initial begin
    seed = 54837;
    {psel, penable, pwrite, busErrPin, slow, nrst, open} = '0;
    {paddr, pwdata, hostOut, safeOut, mcMask, present, lsSel, lastLs, ph, expMax} = '0;
    {tickOn, doneOn, rndOn} = '0;
    clrMon();
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    hostOut <= $random(seed);
    safeOut <= $random(seed);
    apb(0, ADDR_CTRL, 0);
    chk("ctrl", 32'h0, q);
    chk("role", 32'h0, slaveRole);
    apb(0, ADDR_CFG0, 0);
    chk("cfg0", CFG0_RESET, q);
    apb(0, 12'h040, 0);
    chk("unmapped", 32'h1, {q[30:0], err});
    apb(1, ADDR_CTRL, 32'h2);
    repeat (2) @(posedge clk);
    chk("role", 32'h1, slaveRole);
    apb(1, ADDR_CTRL, 32'h0);
    n = 3 + ($random(seed) & 3);
    repeat (n) begin
      busErrPin <= 1'b1;
      repeat (2) @(posedge clk);
      busErrPin <= 1'b0;
      repeat (3) @(posedge clk);
    end
    repeat (5) @(posedge clk);
    apb(0, ADDR_BUSERR, 0);
    chk("buserr", n, q);
    {tickOn, doneOn, rndOn} = 3'b111;
    repeat (400) @(posedge clk);
    {tickOn, doneOn} = 2'b00;
    repeat (20) @(posedge clk);
    apb(0, ADDR_REPCYC, 0);
    chk("repcyc", {12'h0, expMax, expRepN[15:0]}, q);
    apb(0, ADDR_NODX, 0);
    chk("nodx", expNoDx, q);
    apb(0, ADDR_LINKST, 0);
    chk("linkst", lastLs, q);
    apb(1, ADDR_DIAGRST, 32'h1);
    {expRepN, expNoDx, expOv, expMax, rndOn, lsSel} = '0;
    apb(0, ADDR_CYCTIME, 0);
    chk("cyctime", 32'h0000ffff, q);
    apb(0, ADDR_BUSERR, 0);
    chk("buserr clr", 32'h0, q);
    {tickOn, doneOn} = 2'b11;
    repeat (40) @(posedge clk);
    doneOn = 0;
    repeat (100) @(posedge clk);
    tickOn = 0;
    repeat (20) @(posedge clk);
    apb(0, ADDR_OVERRUN, 0);
    chk("overrun", expOv, q);
    // last clean cycle ran from the tick to the done report eight cycles later
    apb(0, ADDR_CYCLAST, 0);
    chk("cyclast", 32'h8, q);
    // clear/operate; zero delays keep the startup short
    apb(1, ADDR_CFG2, 32'h0);
    {tickOn, doneOn} = 2'b11;
    clrMon();
    apb(1, ADDR_CTRL, 32'h100);
    waitOp(1);
    repeat (4) @(posedge clk);
    chk("operate", 32'h1, operate);
    chk("rel up", 32'h1, nRel > 0);
    chk("out", hostOut, slaveOut);
    apb(1, ADDR_CTRL, 32'h310);
    hostOut <= ~hostOut;
    repeat (20) @(posedge clk);
    chk("hold", {24'h0, ~hostOut}, slaveOut);
    apb(1, ADDR_CTRL, 32'h300);
    repeat (20) @(posedge clk);
    chk("zero", 32'h0, slaveOut);
    apb(1, ADDR_CTRL, 32'h108);
    lsSel = 8'h04;
    waitOp(1);
    repeat (40) @(posedge clk);
    chk("aclr all", 32'h0, operate);
    chk("safe", safeOut, slaveOut);
    mcMask <= 8'h04;
    apb(1, ADDR_CTRL, 32'h104);
    repeat (40) @(posedge clk);
    chk("aclr mc", 32'h0, operate);
    mcMask <= 8'h01;
    waitOp(1);
    chk("mc other", 32'h1, operate);
    apb(1, ADDR_CTRL, 32'h100);
    waitOp(1);
    tickOn = 0;
    repeat (60) @(posedge clk);
    chk("missed ticks", 32'h0, operate);
    clrMon();
    apb(1, ADDR_CTRL, 32'h0);
    repeat (60) @(posedge clk);
    chk("rel down", 32'h1, nRel > 0);
    tickOn = 1;
    clrMon();
    apb(1, ADDR_CTRL, 32'h1c0);
    waitOp(1);
    apb(1, ADDR_CTRL, 32'h0c0);
    repeat (60) @(posedge clk);
    chk("no release", 32'h0, nRel);
    {tickOn, doneOn} = 2'b00;
    // presence poll up to station 3, factor 1 times 64 cycles
    present <= 8'h05;
    apb(1, ADDR_CFG1, 32'h40);
    apb(1, ADDR_CFG0, 32'h00010300);
    clrMon();
    apb(1, ADDR_CTRL, 32'h1);
    repeat (3000) @(posedge clk);
    chk("poll addr", 32'h1, seen[3:1] == 3'b111 && seen[127:4] == '0);
    chk("no retry", 32'h0, nRep);
    chk("spacing", 32'h1, minGap >= 64 && lastGap != 0);
    slow <= 1'b1;
    apb(1, ADDR_CFG0, 32'h00010302);
    clrMon();
    repeat (3000) @(posedge clk);
    chk("retry", 32'h1, nRep > 0 && maxRun <= 2);
    apb(1, ADDR_CTRL, 32'h21);
    repeat (2) @(posedge clk);
    clrMon();
    repeat (1000) @(posedge clk);
    chk("listen only", 32'h0, nSend);
    test_done();
  end
endmodule
`default_nettype wire
